/* File: design/eau_map.svh */
// Constants of the effective address unit
`ifndef EAU_MAP_SVH
`define EAU_MAP_SVH

// ----------------------------------------------------------------
// Field positions within the 16-bit instruction word
// ----------------------------------------------------------------
`define EAU_INSN_WIDTH      16
`define EAU_FLD_N_HI       11
`define EAU_FLD_N_LO       8
`define EAU_FLD_M_HI       7
`define EAU_FLD_M_LO       4
`define EAU_FLD_D4_HI      3
`define EAU_FLD_D4_LO      0
`define EAU_FLD_D8_HI      7
`define EAU_FLD_D8_LO      0

// ----------------------------------------------------------------
// Step sizes and reset values
// ----------------------------------------------------------------
`define EAU_STEP_BYTE      32'h0000_0001
`define EAU_STEP_WORD      32'h0000_0002
`define EAU_STEP_LONG      32'h0000_0004
`define EAU_ZERO32         32'h0000_0000

`endif

/* File: design/eau_pkg.sv */
// Types of the effective address unit
`default_nettype none
package eau_pkg;

   // Operand size
   typedef enum logic [1:0] {
      EAU_SZ_BYTE = 2'h0,
      EAU_SZ_WORD = 2'h1,
      EAU_SZ_LONG = 2'h2
   } eau_size_type;

   // Addressing and immediate modes
   typedef enum logic [3:0] {
      EAU_M_REG_DIRECT = 4'h0,
      EAU_M_REG_IND    = 4'h1,
      EAU_M_POST_INC   = 4'h2,
      EAU_M_PRE_DEC    = 4'h3,
      EAU_M_DISP4      = 4'h4,
      EAU_M_IDX_REG    = 4'h5,
      EAU_M_IDX_GBR    = 4'h6,
      EAU_M_GBR_DISP8  = 4'h7,
      EAU_M_PC_REG     = 4'h8,
      EAU_M_IMM_ZERO   = 4'h9,
      EAU_M_IMM_SIGN   = 4'hA,
      EAU_M_TRAP       = 4'hB,
      EAU_M_LOAD_EXT   = 4'hC
   } eau_mode_type;

   // Pipeline stage state
   typedef enum logic [1:0] {
      EAU_ST_IDLE = 2'b01,
      EAU_ST_BUSY = 2'b10
   } eau_state_type;

endpackage : eau_pkg
`default_nettype wire

/* File: design/eau_core.sv */
// Effective address and operand generation stage
`timescale 1ns/1ps
`default_nettype none
`include "eau_map.svh"

// Functional notes
// - Register direct mode returns the selected register as operand with no memory access.
// - Register indirect mode presents the register value as address and leaves it unchanged.
// - Post-increment uses the old value as address and then adds 1, 2 or 4 by size.
// - Pre-decrement subtracts 1, 2 or 4 by size, writes it back and uses it as address.
// - The 4-bit displacement is zero-extended, scaled by size and added to the register.
// - Indexed modes add register zero to the selected register or to the global base.
// - The 8-bit displacement is zero-extended, scaled by size and added to the global base.
// - Register-based PC-relative mode adds the program counter to the selected register.
// - Immediates for test, and, or and exclusive-or are zero-extended to 32 bits.
// - Immediates for move, add and compare-equal are sign-extended to 32 bits.
// - The trap immediate is zero-extended and multiplied by four as vector offset.
// - Only byte immediates come from the instruction word; wider ones come from memory.
// - Fields nnnn, mmmm, dddd and iiii are taken from their fixed instruction positions.
// - Every instruction word is exactly 16 bits and all fields are taken from it.
// - Word accesses off a 2-byte boundary and longword accesses off 4 raise an error.
// - Byte and word memory data are sign-extended to 32 bits for register write.
module eau_core
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                srst,
   // Request from the decoder
   input  wire logic                req_valid,
   input  wire logic [15:0]         insn_word,
   input  wire eau_pkg::eau_mode_type  req_mode,
   input  wire eau_pkg::eau_size_type  req_size,
   input  wire logic                use_m_field,
   // Register file values
   input  wire logic [31:0]         selected_register_value,
   input  wire logic [31:0]         index_register_zero,
   input  wire logic [31:0]         global_base_register,
   input  wire logic [31:0]         program_counter,
   input  wire logic [31:0]         load_data,
   // Results
   output logic                     res_valid,
   output logic                     mem_access,
   output logic [31:0]              mem_address,
   output logic [31:0]              operand_value,
   output logic                     wb_enable,
   output logic [31:0]              wb_value,
   output logic [3:0]               reg_index,
   output logic [3:0]               dest_index,
   output logic                     address_error
);

   // Assertions below share this clock and reset
   default clocking eau_cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] size_step
      (input eau_pkg::eau_size_type sz);
      case (sz)
         eau_pkg::EAU_SZ_BYTE: size_step = `EAU_STEP_BYTE;
         eau_pkg::EAU_SZ_WORD: size_step = `EAU_STEP_WORD;
         default:              size_step = `EAU_STEP_LONG;
      endcase
   endfunction : size_step

   // Scaling by shift keeps the adder single and avoids a multiplier
   function automatic logic [31:0] scale_disp
      (input logic [7:0] d, input eau_pkg::eau_size_type sz);
      logic [31:0] z;
      z = {24'h000000, d};
      case (sz)
         eau_pkg::EAU_SZ_BYTE: scale_disp = z;
         eau_pkg::EAU_SZ_WORD: scale_disp = {z[30:0], 1'b0};
         default:              scale_disp = {z[29:0], 2'b00};
      endcase
   endfunction : scale_disp

   function automatic logic misaligned
      (input logic [31:0] a, input eau_pkg::eau_size_type sz);
      case (sz)
         eau_pkg::EAU_SZ_BYTE: misaligned = 1'b0;
         eau_pkg::EAU_SZ_WORD: misaligned = a[0];
         default:              misaligned = a[1] | a[0];
      endcase
   endfunction : misaligned

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   wire logic [3:0]  fld_n = insn_word[`EAU_FLD_N_HI:`EAU_FLD_N_LO];
   wire logic [3:0]  fld_m = insn_word[`EAU_FLD_M_HI:`EAU_FLD_M_LO];
   wire logic [3:0]  fld_d4 = insn_word[`EAU_FLD_D4_HI:`EAU_FLD_D4_LO];
   // Byte immediate and 8-bit displacement share the low byte
   wire logic [7:0]  fld_i8 = insn_word[`EAU_FLD_D8_HI:`EAU_FLD_D8_LO];
   wire logic [31:0] step = size_step(req_size);
   wire logic [31:0] rn = selected_register_value;

   // ----------------------------------------------------------------
   // Address and operand selection
   // ----------------------------------------------------------------
   logic [31:0] next_addr;
   logic [31:0] next_operand;
   logic [31:0] next_wb;
   logic        next_mem;
   logic        next_wb_en;

   // Sums are 32 bits wide; carries are simply dropped
   always_comb
   begin
      next_addr    = `EAU_ZERO32;
      next_operand = `EAU_ZERO32;
      next_wb      = `EAU_ZERO32;
      next_mem     = 1'b0;
      next_wb_en   = 1'b0;
      case (req_mode)
         eau_pkg::EAU_M_REG_DIRECT:
         begin
            next_operand = rn;
         end
         eau_pkg::EAU_M_REG_IND:
         begin
            next_addr = rn;
            next_mem  = 1'b1;
         end
         eau_pkg::EAU_M_POST_INC:
         begin
            next_addr  = rn;
            next_wb    = rn + step;
            next_wb_en = 1'b1;
            next_mem   = 1'b1;
         end
         eau_pkg::EAU_M_PRE_DEC:
         begin
            next_addr  = rn - step;
            next_wb    = rn - step;
            next_wb_en = 1'b1;
            next_mem   = 1'b1;
         end
         eau_pkg::EAU_M_DISP4:
         begin
            next_addr = rn + scale_disp({4'h0, fld_d4}, req_size);
            next_mem  = 1'b1;
         end
         eau_pkg::EAU_M_IDX_REG:
         begin
            next_addr = rn + index_register_zero;
            next_mem  = 1'b1;
         end
         eau_pkg::EAU_M_IDX_GBR:
         begin
            next_addr = global_base_register + index_register_zero;
            next_mem  = 1'b1;
         end
         eau_pkg::EAU_M_GBR_DISP8:
         begin
            next_addr = global_base_register
                      + scale_disp(fld_i8, req_size);
            next_mem  = 1'b1;
         end
         eau_pkg::EAU_M_PC_REG:
         begin
            next_addr = program_counter + rn;
         end
         eau_pkg::EAU_M_IMM_ZERO:
         begin
            next_operand = {24'h000000, fld_i8};
         end
         eau_pkg::EAU_M_IMM_SIGN:
         begin
            next_operand = {{24{fld_i8[7]}}, fld_i8};
         end
         eau_pkg::EAU_M_TRAP:
         begin
            next_operand = {22'h0, fld_i8, 2'b00};
         end
         eau_pkg::EAU_M_LOAD_EXT:
         begin
            case (req_size)
               eau_pkg::EAU_SZ_BYTE:
                  next_operand = {{24{load_data[7]}}, load_data[7:0]};
               eau_pkg::EAU_SZ_WORD:
                  next_operand = {{16{load_data[15]}}, load_data[15:0]};
               default:
                  next_operand = load_data;
            endcase
         end
         default:
         begin
            next_operand = `EAU_ZERO32;
         end
      endcase
   end

   // Misaligned access suppresses the memory strobe and the write-back
   wire logic next_err = req_valid & next_mem
                       & misaligned(next_addr, req_size);

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   eau_pkg::eau_state_type state;

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         state         <= eau_pkg::EAU_ST_IDLE;
         res_valid     <= 1'b0;
         mem_access    <= 1'b0;
         mem_address   <= `EAU_ZERO32;
         operand_value <= `EAU_ZERO32;
         wb_enable     <= 1'b0;
         wb_value      <= `EAU_ZERO32;
         reg_index     <= 4'h0;
         dest_index    <= 4'h0;
         address_error <= 1'b0;
      end
      else
      begin
         state         <= req_valid ? eau_pkg::EAU_ST_BUSY
                                    : eau_pkg::EAU_ST_IDLE;
         res_valid     <= req_valid;
         mem_access    <= req_valid & next_mem & ~next_err;
         mem_address   <= next_addr;
         operand_value <= next_operand;
         wb_enable     <= req_valid & next_wb_en & ~next_err;
         wb_value      <= next_wb;
         reg_index     <= use_m_field ? fld_m : fld_n;
         dest_index    <= fld_n;
         address_error <= next_err;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_post_req;
      req_valid && req_mode == eau_pkg::EAU_M_POST_INC;
   endsequence

   a_post_inc_old: assert property (
      s_post_req |=> mem_address == $past(rn)
         && wb_value == $past(rn) + $past(step))
      else $error("post-increment address or update wrong");

   a_pre_dec_addr: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_PRE_DEC |=>
         mem_address == wb_value && wb_value == $past(rn) - $past(step))
      else $error("pre-decrement address differs from update");

   a_direct_nomem: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_REG_DIRECT |=>
         !mem_access && operand_value == $past(rn))
      else $error("register direct made a memory access");

   a_ind_noupd: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_REG_IND |=>
         !wb_enable && mem_address == $past(rn))
      else $error("register indirect changed the register");

   a_idx_gbr_sum: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_IDX_GBR |=>
         mem_address == $past(global_base_register)
                      + $past(index_register_zero))
      else $error("indexed base address wrong");

   a_trap_vector: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_TRAP |=>
         operand_value[1:0] == 2'h0
         && operand_value[9:2] == $past(insn_word[7:0]))
      else $error("trap vector offset wrong");

   a_sign_imm: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_IMM_SIGN |=>
         operand_value[31:8] == {24{operand_value[7]}})
      else $error("signed immediate not extended");

   a_zero_imm: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_IMM_ZERO |=>
         operand_value[31:8] == 24'h000000)
      else $error("logic immediate not zero-extended");

   a_align_err: assert property (
      address_error |-> !mem_access && !wb_enable
         && (mem_address[0] || mem_address[1]))
      else $error("address error without misalignment");

   a_field_index: assert property (
      req_valid |=> res_valid && state == eau_pkg::EAU_ST_BUSY
         && dest_index == $past(insn_word[11:8]))
      else $error("result valid or destination field wrong");

   a_disp4_word: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_DISP4
         && req_size == eau_pkg::EAU_SZ_WORD |=>
         mem_address == $past(rn) + {27'h0, $past(insn_word[3:0]), 1'b0})
      else $error("word displacement address wrong");

   a_gbr_disp_long: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_GBR_DISP8
         && req_size == eau_pkg::EAU_SZ_LONG |=>
         mem_address == $past(global_base_register)
                      + {22'h0, $past(insn_word[7:0]), 2'b00})
      else $error("long base displacement address wrong");

   a_pc_target: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_PC_REG |=>
         !mem_access
         && mem_address == $past(program_counter) + $past(rn))
      else $error("register-relative target wrong");

   a_load_byte: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_LOAD_EXT
         && req_size == eau_pkg::EAU_SZ_BYTE |=>
         operand_value == {{24{$past(load_data[7])}},
                           $past(load_data[7:0])})
      else $error("byte load not sign-extended");

   // Word access from an odd base with any displacement must be flagged
   a_word_misalign: assert property (
      req_valid && req_mode == eau_pkg::EAU_M_GBR_DISP8
         && req_size == eau_pkg::EAU_SZ_WORD
         && global_base_register[0] |=> address_error && !mem_access)
      else $error("odd word address not flagged");

endmodule : eau_core
`default_nettype wire

/* File: testbench/eau_regs.sv */
// Register file model on the decoder side of the unit
`timescale 1ns/1ps
`default_nettype none
module eau_regs
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // Read port
   input  wire logic [3:0]  rd_index,
   output logic [31:0]      rd_value,
   // Write-back port
   input  wire logic        wr_enable,
   input  wire logic [3:0]  wr_index,
   input  wire logic [31:0] wr_value
);
   logic [31:0] regs [16];

   assign rd_value = regs[rd_index];

   // Known values per register so every address is predictable
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 16; i++)
            regs[i] <= {20'h0, 4'(i), 8'h0};
      end
      else if (wr_enable)
      begin
         regs[wr_index] <= wr_value;
      end
   end
endmodule : eau_regs
`default_nettype wire

/* File: testbench/tb_effective_address_unit.sv */
// Self-checking bench of the effective address unit
`timescale 1ns/1ps
`default_nettype none
module tb_effective_address_unit;
   logic                  ref_clk = 1'b0;
   logic                  srst = 1'b1;
   logic                  req_valid = 1'b0;
   logic [15:0]           insn_word = 16'h0000;
   eau_pkg::eau_mode_type req_mode = eau_pkg::EAU_M_REG_DIRECT;
   eau_pkg::eau_size_type req_size = eau_pkg::EAU_SZ_BYTE;
   logic                  use_m_field = 1'b0;
   logic [31:0]           index_register_zero = 32'h0000_0010;
   logic [31:0]           global_base_register = 32'h0000_1000;
   logic [31:0]           program_counter = 32'hFFFF_FF00;
   logic [31:0]           load_data = 32'h0000_0000;
   logic [31:0]           reg_value;
   logic                  res_valid, mem_access, wb_enable, address_error;
   logic [31:0]           mem_address, operand_value, wb_value;
   logic [3:0]            reg_index, dest_index;
   logic [31:0]           rf [16];
   int                    err_count = 0;
   int                    cmp_count = 0;
   wire  [3:0]            sel = use_m_field ? insn_word[7:4] : insn_word[11:8];

   always #12.5 ref_clk = ~ref_clk;

   eau_core dut_u (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
      .insn_word(insn_word), .req_mode(req_mode), .req_size(req_size),
      .use_m_field(use_m_field), .selected_register_value(reg_value),
      .index_register_zero(index_register_zero),
      .global_base_register(global_base_register),
      .program_counter(program_counter), .load_data(load_data),
      .res_valid(res_valid), .mem_access(mem_access),
      .mem_address(mem_address), .operand_value(operand_value),
      .wb_enable(wb_enable), .wb_value(wb_value), .reg_index(reg_index),
      .dest_index(dest_index), .address_error(address_error));

   eau_regs regs_u (.ref_clk(ref_clk), .srst(srst), .rd_index(sel),
      .rd_value(reg_value), .wr_enable(wb_enable), .wr_index(reg_index),
      .wr_value(wb_value));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %08h expected %08h", $time, seen, exp);
      end
   endtask : chk

   function automatic eau_pkg::eau_size_type sz(input int k);
      return eau_pkg::eau_size_type'(k);
   endfunction : sz

   // One request, answer looked at in its single valid cycle
   task automatic send(input eau_pkg::eau_mode_type m,
      input eau_pkg::eau_size_type s, input logic [15:0] w, input logic um);
      @(posedge ref_clk);
      #2;
      req_valid = 1'b1;
      req_mode = m;
      req_size = s;
      insn_word = w;
      use_m_field = um;
      @(posedge ref_clk);
      #2;
      req_valid = 1'b0;
      chk(res_valid, 1'b1);
   endtask : send

   task automatic done(input string name);
      $display("Test %s finished, %0d mismatches so far", name, err_count);
   endtask : done

   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      send(eau_pkg::EAU_M_REG_DIRECT, sz(2), 16'h03A0, 1'b1);
      chk(operand_value, rf[10]);
      chk(mem_access, 1'b0);
      chk(reg_index, 4'hA);
      chk(dest_index, 4'h3);
      send(eau_pkg::EAU_M_REG_IND, sz(2), 16'h0400, 1'b0);
      chk(mem_address, rf[4]);
      chk(reg_index, 4'h4);
      chk({mem_access, wb_enable}, 2'b10);
      done("register");
   endtask : t_regs

   // Longword first keeps the wrapped pre-decrement addresses aligned
   task automatic t_step();
      logic [31:0] a;
      for (int k = 2; k >= 0; k--)
      begin
         a = rf[k + 1];
         send(eau_pkg::EAU_M_POST_INC, sz(k), {4'h0, 4'(k + 1), 8'h0}, 1'b0);
         chk(mem_address, a);
         chk(wb_enable, 1'b1);
         chk(wb_value, a + (32'h1 << k));
         rf[k + 1] = a + (32'h1 << k);
         a = rf[0] - (32'h1 << k);
         send(eau_pkg::EAU_M_PRE_DEC, sz(k), 16'h0000, 1'b0);
         chk(mem_address, a);
         chk(wb_enable, 1'b1);
         chk(wb_value, a);
         rf[0] = a;
      end
      send(eau_pkg::EAU_M_REG_DIRECT, sz(2), 16'h0000, 1'b0);
      chk(operand_value, rf[0]);
      send(eau_pkg::EAU_M_REG_DIRECT, sz(2), 16'h0300, 1'b0);
      chk(operand_value, rf[3]);
      done("step");
   endtask : t_step

   task automatic t_disp();
      for (int k = 0; k < 3; k++)
      begin
         send(eau_pkg::EAU_M_DISP4, sz(k), 16'h05FF, 1'b0);
         chk(mem_address, rf[5] + (32'hF << k));
         send(eau_pkg::EAU_M_GBR_DISP8, sz(k), 16'hC5FF, 1'b0);
         chk(mem_address, 32'h1000 + (32'hFF << k));
      end
      send(eau_pkg::EAU_M_IDX_REG, sz(2), 16'h0600, 1'b0);
      chk(mem_address, rf[6] + 32'h10);
      send(eau_pkg::EAU_M_IDX_GBR, sz(2), 16'h0600, 1'b0);
      chk(mem_address, 32'h1010);
      send(eau_pkg::EAU_M_PC_REG, sz(2), 16'h0070, 1'b1);
      chk(mem_address, 32'hFFFF_FF00 + rf[7]);
      chk(mem_access, 1'b0);
      done("displacement");
   endtask : t_disp

   task automatic t_imm();
      send(eau_pkg::EAU_M_IMM_ZERO, sz(0), 16'hC380, 1'b0);
      chk(operand_value, 32'h0000_0080);
      send(eau_pkg::EAU_M_IMM_SIGN, sz(0), 16'hC380, 1'b0);
      chk(operand_value, 32'hFFFF_FF80);
      send(eau_pkg::EAU_M_IMM_SIGN, sz(0), 16'hC37F, 1'b0);
      chk(operand_value, 32'h0000_007F);
      send(eau_pkg::EAU_M_TRAP, sz(0), 16'hC3FF, 1'b0);
      chk(operand_value, 32'h0000_03FC);
      done("immediate");
   endtask : t_imm

   // Base value, size and expected error flag per row
   task automatic t_align();
      logic [34:0] tbl [5] = '{{32'h1, 2'h0, 1'b0}, {32'h1, 2'h1, 1'b1},
         {32'h2, 2'h2, 1'b1}, {32'h2, 2'h1, 1'b0}, {32'h4, 2'h2, 1'b0}};
      foreach (tbl[i])
      begin
         global_base_register = tbl[i][34:3];
         send(eau_pkg::EAU_M_GBR_DISP8, sz(tbl[i][2:1]), 16'h0000, 1'b0);
         chk({address_error, mem_access}, {tbl[i][0], ~tbl[i][0]});
      end
      global_base_register = 32'h0000_1000;
      done("alignment");
   endtask : t_align

   task automatic t_load();
      logic [63:0] tbl [4] = '{{32'h1234_5680, 32'hFFFF_FF80},
         {32'h1234_8001, 32'hFFFF_8001}, {32'h1234_567F, 32'h0000_007F},
         {32'h8765_4321, 32'h8765_4321}};
      foreach (tbl[i])
      begin
         load_data = tbl[i][63:32];
         send(eau_pkg::EAU_M_LOAD_EXT, sz(i == 3 ? 2 : i % 2), 16'h0000,
            1'b0);
         chk(operand_value, tbl[i][31:0]);
      end
      done("load");
   endtask : t_load

   initial
   begin
      for (int i = 0; i < 16; i++)
         rf[i] = {20'h0, 4'(i), 8'h0};
      repeat (16) @(posedge ref_clk);
      #2;
      srst = 1'b0;
      chk({res_valid, mem_access, wb_enable, address_error}, 4'h0);
      t_regs();
      t_step();
      t_disp();
      t_imm();
      t_align();
      t_load();
      stop_test();
   end
endmodule : tb_effective_address_unit
`default_nettype wire
